// ### hw/bdm_decode.sv
/*
 * Banked data memory decoder: splits direct and indirect accesses into
 * core, special function, general purpose and common regions, keeps
 * the bank select and two file select pointers, and reads program
 * memory through a pointer with its top bit set.
 * Assumes the core datapath holds core and special function registers
 * and answers their reads combinationally from the registered selects,
 * and that program memory answers combinationally from o_prog_addr.
 */
`timescale 1ns/1ps
`include "bdm_defs.svh"

module bdm_decode
    import bdm_pkg::*;
#(
    parameter int GPR_BANKS = 12,
    parameter int PROG_AW = 15
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_req,
    input wire logic i_indirect,
    input wire logic i_ptr_sel,
    input wire logic i_wr,
    input wire logic [6:0] i_file_ofs,
    input wire logic [7:0] i_wdata,
    input wire logic i_bank_wr,
    input wire logic [4:0] i_bank_wdata,
    input wire logic i_ptr_wr,
    input wire logic i_ptr_wsel,
    input wire logic [15:0] i_ptr_wdata,
    input wire logic [7:0] i_core_rdata,
    input wire logic [7:0] i_sfr_rdata,
    input wire logic i_sfr_impl,
    input wire logic [13:0] i_prog_rdata,
    output logic o_busy,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    output logic o_core_sel,
    output logic o_sfr_sel,
    output logic o_wr,
    output logic [11:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_prog_rd,
    output logic [PROG_AW-1:0] o_prog_addr,
    output logic [4:0] o_bank_select
);

    localparam int DEPTH = GPR_BANKS * `BDM_GPR_BYTES + `BDM_COMMON_BYTES;
    localparam int AW = $clog2(DEPTH);

    generate
        if (GPR_BANKS < 1 || GPR_BANKS > `BDM_NUM_BANKS || PROG_AW < 1 || PROG_AW > 15)
        begin : g_chk
            $error("bdm_decode: parameter out of range");
        end
    endgenerate

    // ============================================================
    // decode helpers
    // region bounds
    function automatic bdm_region_t region_of(input logic [6:0] ofs);
        if (ofs <= `BDM_CORE_LAST)
            return BDM_REG_CORE;
        else if (ofs < `BDM_GPR_FIRST)
            return BDM_REG_SFR;
        else if (ofs < `BDM_COMMON_FIRST)
            return BDM_REG_GPR;
        else
            return BDM_REG_COMMON;
    endfunction

    bdm_state_t state;
    logic [4:0] bank_select_reg;
    logic [15:0] file_select_pointer [0:1];
    logic [AW-1:0] ram_index;
    logic ram_wr;
    logic ram_impl;
    logic hold_gpr;
    logic [7:0] prog_low;
    logic [7:0] ram_rdata;

    wire logic [15:0] ptr_word = file_select_pointer[i_ptr_sel];
    wire logic [7:0] pointer_high_byte = ptr_word[15:8];
    // program fetch when pointer top bit set
    wire logic to_prog = i_indirect && pointer_high_byte[7];
    // bank from bank select or pointer
    wire logic [4:0] acc_bank = i_indirect ? ptr_word[11:7] : bank_select_reg;
    wire logic [6:0] acc_ofs = i_indirect ? ptr_word[6:0] : i_file_ofs;
    wire logic [11:0] acc_addr = {acc_bank, acc_ofs};
    wire bdm_region_t acc_region = region_of(acc_ofs);
    wire logic take = i_req && (state == BDM_ST_IDLE);
    wire integer gpr_idx = int'(acc_bank) * `BDM_GPR_BYTES + int'(acc_ofs) - int'(`BDM_GPR_FIRST);
    wire integer com_idx = GPR_BANKS * `BDM_GPR_BYTES + int'(acc_ofs[3:0]);
    wire logic gpr_present = int'(acc_bank) < GPR_BANKS;
    wire logic [AW-1:0] next_index = (acc_region == BDM_REG_COMMON) ? com_idx[AW-1:0] : gpr_idx[AW-1:0];
    wire logic next_ram_impl = (acc_region == BDM_REG_COMMON) || gpr_present;
    wire logic is_ram = (acc_region == BDM_REG_GPR) || (acc_region == BDM_REG_COMMON);

    // zero for unimplemented bytes and unimplemented special registers
    wire logic [7:0] data_read = hold_gpr ? (ram_impl ? ram_rdata : `BDM_DATA_ZERO) :
                                 o_core_sel ? i_core_rdata :
                                 (o_sfr_sel && i_sfr_impl) ? i_sfr_rdata : `BDM_DATA_ZERO;

    // ============================================================
    // byte storage
    bdm_ram #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_ram (
        .i_clk_sys(i_clk_sys),
        .i_wr(ram_wr),
        .i_index(ram_index),
        .i_wdata(o_wdata),
        .o_rdata(ram_rdata)
    );

    // ============================================================
    // bank select and pointers
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            bank_select_reg <= `BDM_BANK_RESET;
            file_select_pointer[0] <= `BDM_PTR_RESET;
            file_select_pointer[1] <= `BDM_PTR_RESET;
        end
        else
        begin
            if (i_bank_wr)
                bank_select_reg <= i_bank_wdata;
            if (i_ptr_wr)
                file_select_pointer[i_ptr_wsel] <= i_ptr_wdata;
        end
    end

    // ============================================================
    // access sequencer
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            state <= BDM_ST_IDLE;
            o_core_sel <= 1'b0;
            o_sfr_sel <= 1'b0;
            o_wr <= 1'b0;
            o_addr <= 12'h000;
            o_wdata <= 8'h00;
            o_prog_rd <= 1'b0;
            o_prog_addr <= '0;
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h00;
            ram_index <= '0;
            ram_wr <= 1'b0;
            ram_impl <= 1'b0;
            hold_gpr <= 1'b0;
            prog_low <= 8'h00;
        end
        else
        begin
            o_rd_valid <= 1'b0;
            o_prog_rd <= 1'b0;
            ram_wr <= 1'b0;
            case (state)
                BDM_ST_IDLE:
                begin
                    o_core_sel <= 1'b0;
                    o_sfr_sel <= 1'b0;
                    o_wr <= 1'b0;
                    hold_gpr <= 1'b0;
                    if (take && to_prog)
                    begin
                        if (!i_wr)
                        begin
                            o_prog_rd <= 1'b1;
                            o_prog_addr <= ptr_word[PROG_AW-1:0];
                            state <= BDM_ST_PROG1;
                        end
                    end
                    else if (take)
                    begin
                        // core offsets hit the core registers in any bank
                        o_core_sel <= (acc_region == BDM_REG_CORE);
                        o_sfr_sel <= (acc_region == BDM_REG_SFR);
                        o_wr <= i_wr;
                        o_addr <= acc_addr;
                        o_wdata <= i_wdata;
                        ram_index <= next_index;
                        ram_impl <= next_ram_impl;
                        hold_gpr <= is_ram;
                        ram_wr <= i_wr && is_ram && next_ram_impl;
                        state <= BDM_ST_DATA;
                    end
                end
                BDM_ST_DATA:
                begin
                    o_rd_valid <= !o_wr;
                    o_rd_data <= o_wr ? o_rd_data : data_read;
                    o_core_sel <= 1'b0;
                    o_sfr_sel <= 1'b0;
                    o_wr <= 1'b0;
                    state <= BDM_ST_IDLE;
                end
                BDM_ST_PROG1:
                begin
                    // keep only the low eight bits
                    prog_low <= i_prog_rdata[7:0];
                    state <= BDM_ST_PROG2;
                end
                BDM_ST_PROG2:
                begin
                    o_rd_valid <= 1'b1;
                    o_rd_data <= prog_low;
                    state <= BDM_ST_IDLE;
                end
                default:
                begin
                    state <= BDM_ST_IDLE;
                end
            endcase
        end
    end

    // busy and bank view from flops
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_busy <= 1'b0;
            o_bank_select <= `BDM_BANK_RESET;
        end
        else
        begin
            o_busy <= (state == BDM_ST_IDLE) ? (take && !(to_prog && i_wr)) : (state == BDM_ST_PROG1);
            o_bank_select <= i_bank_wr ? i_bank_wdata : bank_select_reg;
        end
    end

endmodule // bdm_decode

// ### hw/bdm_defs.svh
/*
 * Constants of the banked data memory decoder: bank geometry, in-bank
 * region bounds, pointer layout and reset values.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef BDM_DEFS_SVH
`define BDM_DEFS_SVH

// ============================================================
// bank geometry
`define BDM_NUM_BANKS 32
`define BDM_BANK_BYTES 128
`define BDM_ADDR_BITS 12
`define BDM_BANK_BITS 5
`define BDM_OFS_BITS 7

// ============================================================
// in-bank regions
`define BDM_CORE_COUNT 12
`define BDM_CORE_LAST 7'h0B
`define BDM_SFR_FIRST 7'h0C
`define BDM_GPR_FIRST 7'h20
`define BDM_GPR_BYTES 80
`define BDM_COMMON_FIRST 7'h70
`define BDM_COMMON_BYTES 16

// ============================================================
// pointer layout and reset values
`define BDM_PTR_PROG_BIT 15
`define BDM_PTR_RESET 16'h0000
`define BDM_BANK_RESET 5'h00
`define BDM_DATA_ZERO 8'h00

`endif

// ### hw/bdm_pkg.sv
/*
 * Types of the banked data memory decoder.
 * Assumes bdm_defs.svh for the numbers.
 */
package bdm_pkg;

    // region of an in-bank offset
    typedef enum logic [2:0] {
        BDM_REG_CORE,
        BDM_REG_SFR,
        BDM_REG_GPR,
        BDM_REG_COMMON
    } bdm_region_t;

    // access sequencer states
    typedef enum logic [1:0] {
        BDM_ST_IDLE,
        BDM_ST_DATA,
        BDM_ST_PROG1,
        BDM_ST_PROG2
    } bdm_state_t;

endpackage

// ### hw/bdm_ram.sv
/*
 * Byte RAM behind the decoder: banked general purpose bytes plus the
 * shared common bytes, one write port and an unregistered read.
 * Assumes the caller presents a registered index.
 */
`timescale 1ns/1ps

module bdm_ram
    import bdm_pkg::*;
#(
    parameter int DEPTH = 976,
    parameter int AW = 10
)
(
    input wire logic i_clk_sys,
    input wire logic i_wr,
    input wire logic [AW-1:0] i_index,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);

    // ============================================================
    // storage
    logic [7:0] mem [0:DEPTH-1];

    generate
        if (DEPTH < 1 || DEPTH > (1 << AW))
        begin : g_chk
            $error("bdm_ram: depth does not fit index width");
        end
    endgenerate

    // write port; contents need no reset
    always_ff @(posedge i_clk_sys)
    begin
        if (i_wr)
            mem[i_index] <= i_wdata;
    end

    // read port, out-of-range reads zero
    assign o_rdata = (int'(i_index) < DEPTH) ? mem[i_index] : 8'h00;

endmodule // bdm_ram

// ### verification/bdm_core_model.sv
/* core datapath stand-in: core, special and program reads.
   assumes the decoder's registered selects and addresses. */
`timescale 1ns/1ps
// ==========
// core model
module bdm_core_model (
    input wire logic o_core_sel,
    input wire logic o_sfr_sel,
    input wire logic [11:0] o_addr,
    input wire logic [14:0] o_prog_addr,
    output logic [7:0] i_core_rdata,
    output logic [7:0] i_sfr_rdata,
    output logic i_sfr_impl,
    output logic [13:0] i_prog_rdata
);
    wire [7:0] core_val = {1'h1, o_addr[6:0]};
    wire [7:0] sfr_val = {3'h2, o_addr[4:0]};
    // core bytes; unselected shows the inverse, never stale data
    assign i_core_rdata = o_core_sel ? core_val : ~core_val;
    assign i_sfr_rdata = o_sfr_sel ? sfr_val : ~sfr_val;
    assign i_sfr_impl = o_addr[0];
    // upper bits set so a missing mask shows
    assign i_prog_rdata = {o_prog_addr[5:0], o_prog_addr[7:0] ^ 8'h5A};
endmodule // bdm_core_model

// ### verification/bdm_decode_asserts.sv
/* port checker of the banked data memory decoder.
   assumes the bind below and pointer loads apart from takes. */
`timescale 1ns/1ps
// ==========
// checker
module bdm_decode_asserts #(
    parameter int PROG_AW = 15
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_req,
    input wire logic i_indirect,
    input wire logic i_ptr_sel,
    input wire logic i_wr,
    input wire logic [6:0] i_file_ofs,
    input wire logic [7:0] i_wdata,
    input wire logic i_bank_wr,
    input wire logic [4:0] i_bank_wdata,
    input wire logic i_ptr_wr,
    input wire logic i_ptr_wsel,
    input wire logic [15:0] i_ptr_wdata,
    input wire logic o_busy,
    input wire logic o_rd_valid,
    input wire logic o_core_sel,
    input wire logic o_sfr_sel,
    input wire logic o_wr,
    input wire logic [7:0] o_wdata,
    input wire logic [11:0] o_addr,
    input wire logic o_prog_rd,
    input wire logic [PROG_AW-1:0] o_prog_addr,
    input wire logic [4:0] o_bank_select
);
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    // take decode; o_busy is low exactly while the sequencer idles
    wire [15:0] cur = i_ptr_sel ? ptr1 : ptr0;
    wire tk = i_req && !o_busy;
    wire prog = i_indirect && cur[15];
    wire [6:0] ofs = i_indirect ? cur[6:0] : i_file_ofs;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // shadow pointers
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset || (i_ptr_wr && !i_ptr_wsel))
            ptr0 <= i_reset ? 16'h0000 : i_ptr_wdata;
        if (i_reset || (i_ptr_wr && i_ptr_wsel))
            ptr1 <= i_reset ? 16'h0000 : i_ptr_wdata;
    end
    sequence s_data;
        ##1 !o_rd_valid ##1 o_rd_valid;
    endsequence
    sequence s_prog;
        ##1 o_prog_rd ##1 !o_rd_valid ##1 o_rd_valid;
    endsequence
    // busy spans the access: one cycle for data, two for program
    sequence s_busy_data;
        o_busy ##1 !o_busy;
    endsequence
    sequence s_busy_prog;
        o_busy ##1 o_busy ##1 !o_busy;
    endsequence
    data_read_a: assert property (tk && !i_wr && !prog |-> s_data)
        else $error("late data read");
    prog_read_a: assert property (tk && !i_wr && prog |-> s_prog)
        else $error("late program read");
    prog_wr_drop_a: assert property (tk && i_wr && prog |=> !(o_wr || o_prog_rd || o_core_sel || o_sfr_sel))
        else $error("program write not dropped");
    bank_load_a: assert property (i_bank_wr |=> o_bank_select == $past(i_bank_wdata))
        else $error("bank not loaded");
    direct_addr_a: assert property (tk && !i_indirect |=>
        o_addr == {$past(o_bank_select), $past(i_file_ofs)})
        else $error("direct address wrong");
    ind_addr_a: assert property (tk && i_indirect && !cur[15] |=> o_addr == $past(cur[11:0]))
        else $error("indirect address wrong");
    core_sel_a: assert property (tk && !prog && ofs < 7'h0C |=> o_core_sel && !o_sfr_sel)
        else $error("core select missing");
    prog_addr_a: assert property (tk && !i_wr && prog |=>
        o_prog_rd && o_prog_addr == $past(cur[PROG_AW-1:0]))
        else $error("program address wrong");
    busy_data_a: assert property (tk && !prog |=> s_busy_data)
        else $error("data busy wrong");
    busy_prog_a: assert property (tk && !i_wr && prog |=> s_busy_prog)
        else $error("program busy wrong");
    wr_data_a: assert property (tk && i_wr && !prog |=> o_wr && o_wdata == $past(i_wdata))
        else $error("write data wrong");
endmodule // bdm_decode_asserts

bind bdm_decode bdm_decode_asserts #(.PROG_AW(PROG_AW)) u_chk (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req(i_req), .i_indirect(i_indirect),
    .i_ptr_sel(i_ptr_sel), .i_wr(i_wr), .i_file_ofs(i_file_ofs), .i_wdata(i_wdata),
    .i_bank_wr(i_bank_wr), .i_bank_wdata(i_bank_wdata), .i_ptr_wr(i_ptr_wr), .i_ptr_wsel(i_ptr_wsel),
    .i_ptr_wdata(i_ptr_wdata), .o_busy(o_busy), .o_rd_valid(o_rd_valid), .o_core_sel(o_core_sel),
    .o_sfr_sel(o_sfr_sel), .o_wr(o_wr), .o_wdata(o_wdata), .o_addr(o_addr), .o_prog_rd(o_prog_rd),
    .o_prog_addr(o_prog_addr), .o_bank_select(o_bank_select)
);

// ### verification/tb_banked_data_memory_decode.sv
/* self-checking bench of the banked data memory decoder.
   assumes the decoder, the core model and the bound checker. */
`timescale 1ns/1ps
// ==========
// bench top
module tb_banked_data_memory_decode;
    logic i_clk_sys = 1'h0;
    logic i_reset = 1'h1;
    logic i_req = 1'h0, i_indirect = 1'h0, i_ptr_sel = 1'h0, i_wr = 1'h0;
    logic i_bank_wr = 1'h0, i_ptr_wr = 1'h0, i_ptr_wsel = 1'h0;
    logic [6:0] i_file_ofs = 7'h00;
    logic [7:0] i_wdata = 8'h00;
    logic [4:0] i_bank_wdata = 5'h00;
    logic [15:0] i_ptr_wdata = 16'h0000;
    logic [7:0] i_core_rdata, i_sfr_rdata, o_rd_data, o_wdata, rd;
    logic [13:0] i_prog_rdata;
    logic i_sfr_impl, o_busy, o_rd_valid, o_core_sel, o_sfr_sel, o_wr, o_prog_rd;
    logic [11:0] o_addr;
    logic [14:0] o_prog_addr;
    logic [4:0] o_bank_select;
    int n_errors = 0;
    int n_tests = 0;
    bdm_decode u_dut (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req(i_req), .i_indirect(i_indirect),
        .i_ptr_sel(i_ptr_sel), .i_wr(i_wr), .i_file_ofs(i_file_ofs), .i_wdata(i_wdata),
        .i_bank_wr(i_bank_wr), .i_bank_wdata(i_bank_wdata), .i_ptr_wr(i_ptr_wr), .i_ptr_wsel(i_ptr_wsel),
        .i_ptr_wdata(i_ptr_wdata), .i_core_rdata(i_core_rdata), .i_sfr_rdata(i_sfr_rdata),
        .i_sfr_impl(i_sfr_impl), .i_prog_rdata(i_prog_rdata), .o_busy(o_busy), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .o_core_sel(o_core_sel), .o_sfr_sel(o_sfr_sel), .o_wr(o_wr),
        .o_addr(o_addr), .o_wdata(o_wdata), .o_prog_rd(o_prog_rd), .o_prog_addr(o_prog_addr),
        .o_bank_select(o_bank_select)
    );
    bdm_core_model u_core (
        .o_core_sel(o_core_sel), .o_sfr_sel(o_sfr_sel), .o_addr(o_addr), .o_prog_addr(o_prog_addr),
        .i_core_rdata(i_core_rdata), .i_sfr_rdata(i_sfr_rdata), .i_sfr_impl(i_sfr_impl),
        .i_prog_rdata(i_prog_rdata)
    );
    // 25 MHz clock
    initial
    begin
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp);
        n_tests++;
        if (rd !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, rd);
        end
    endtask
    // k = {pointer, which}; a bank load when pointer is 0
    task automatic ld(input logic [1:0] k, input logic [15:0] v);
        @(posedge i_clk_sys);
        i_bank_wr <= !k[1];
        {i_ptr_wr, i_ptr_wsel} <= k;
        i_bank_wdata <= v[4:0];
        i_ptr_wdata <= v;
        @(posedge i_clk_sys);
        {i_bank_wr, i_ptr_wr} <= 2'h0;
    endtask
    // m = {indirect, pointer, write}; waits out the slowest answer
    task automatic acc(input logic [2:0] m, input logic [6:0] ofs, input logic [7:0] wd);
        @(posedge i_clk_sys);
        i_req <= 1'h1;
        {i_indirect, i_ptr_sel, i_wr} <= m;
        i_file_ofs <= ofs;
        i_wdata <= wd;
        @(posedge i_clk_sys);
        i_req <= 1'h0;
        rd = 'x;
        repeat (4)
        begin
            @(posedge i_clk_sys);
            #1;
            if (o_rd_valid === 1'h1)
                rd = o_rd_data;
        end
    endtask
    // banks kept apart, shared bytes not, absent banks zero
    task automatic t_bank();
        ld(2'h0, 16'h0005);
        acc(3'h1, 7'h20, 8'h3C);
        acc(3'h1, 7'h75, 8'h5A);
        ld(2'h0, 16'h0006);
        acc(3'h1, 7'h20, 8'hC3);
        ld(2'h0, 16'h0005);
        acc(3'h0, 7'h20, 8'h00);
        chk("bank5 byte", 8'h3C);
        ld(2'h0, 16'h001F);
        acc(3'h0, 7'h20, 8'h00);
        chk("bank31 byte", 8'h00);
        acc(3'h0, 7'h75, 8'h00);
        chk("shared byte", 8'h5A);
    endtask
    // core and special registers through the model; the core write is judged by the checker
    task automatic t_regs();
        ld(2'h0, 16'h0007);
        acc(3'h1, 7'h05, 8'h11);
        acc(3'h0, 7'h05, 8'h00);
        chk("core reg", 8'h85);
        acc(3'h0, 7'h0D, 8'h00);
        chk("special reg", 8'h4D);
        acc(3'h0, 7'h0E, 8'h00);
        chk("absent reg", 8'h00);
    endtask
    // pointer data read and write, program read, dropped program write
    task automatic t_ind();
        ld(2'h2, 16'h0320);
        acc(3'h4, 7'h00, 8'h00);
        chk("pointer data", 8'hC3);
        acc(3'h5, 7'h00, 8'h96);
        acc(3'h4, 7'h00, 8'h00);
        chk("pointer write", 8'h96);
        ld(2'h3, 16'h80F5);
        acc(3'h6, 7'h00, 8'h00);
        chk("program low", 8'hAF);
        acc(3'h7, 7'h00, 8'hEE);
        acc(3'h0, 7'h75, 8'h00);
        chk("after drop", 8'h5A);
    endtask
    // mid-run reset: bank select and pointer 0 back to zero
    task automatic t_rst();
        @(posedge i_clk_sys);
        i_reset <= 1'h1;
        repeat (2) @(posedge i_clk_sys);
        i_reset <= 1'h0;
        @(posedge i_clk_sys);
        #1;
        rd = {3'h0, o_bank_select};
        chk("bank after reset", 8'h00);
        acc(3'h4, 7'h00, 8'h00);
        chk("pointer after reset", 8'h80);
    endtask
    // watchdog, far beyond the roughly 130 cycles needed
    initial
    begin
        #100000;
        n_errors++;
        conclude();
    end
    initial
    begin
        repeat (10) @(posedge i_clk_sys);
        i_reset <= 1'h0;
        t_bank();
        t_regs();
        t_ind();
        t_rst();
        conclude();
    end
endmodule // tb_banked_data_memory_decode
